// ===== inc/atx_defs.vh
// Constants for the transport stream transmit framer
`ifndef ATX_DEFS_VH
`define ATX_DEFS_VH
`define ATX_SYNC_BYTE     8'h47
`define ATX_NULL_PID_HI   8'h1f
`define ATX_NULL_PID_LO   8'hff
`define ATX_NULL_FLAGS    8'h10
`define ATX_NULL_FILL     8'hff
`define ATX_LEN_188       8'd188
`define ATX_LEN_204       8'd204
`define ATX_LAST_188      8'd187
`define ATX_LAST_204      8'd203
`define ATX_RS_BYTES      8'd16
`define ATX_IDX_PID_HI    8'd1
`define ATX_IDX_PID_LO    8'd2
`define ATX_IDX_FLAGS     8'd3
`define ATX_LOSS_FRAMES   4'd3
`define ATX_PRBS11_TAP_A  10
`define ATX_PRBS11_TAP_B  8
`define ATX_PRBS23_TAP_A  22
`define ATX_PRBS23_TAP_B  17
`define ATX_PRBS_SEED     23'h00_0001
`define ATX_PPM_WINDOW    16'd100
`define ATX_LINE_MBPS     16'd270
`define ATX_BW_WIDE_MHZ   16'd2000
`define ATX_BW_NARROW_MHZ 16'd500
`define ATX_PCR_SETTLE_NS 16'd500
`define ATX_PCR_FINAL_NS  16'd100
`define ATX_PCR_SETTLE_S  16'd20
`define ATX_CLK_HZ        32'd10000000
`define ATX_SETTLE_CYC    (`ATX_PCR_SETTLE_S * `ATX_CLK_HZ)
`endif

// ===== src/atx_buf2.v
// Two-entry elastic buffer with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module atx_buf2 (
	// Clock and control
	input  wire       clk,
	input  wire       clk_en,
	input  wire       sys_rst,
	// Fill side
	input  wire       in_valid,
	output wire       in_ready,
	input  wire [8:0] in_data,
	// Drain side
	output wire       out_valid,
	input  wire       out_ready,
	output reg  [8:0] out_data,
	// Fault
	output wire       overflow
);
	reg  [8:0] spare;
	reg  [1:0] count;
	wire       push;
	wire       pop;

	assign in_ready  = (count != 2'd2);
	assign out_valid = (count != 2'd0);
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign overflow  = in_valid & ~in_ready;

	// Head is out_data, second word waits in spare
	always @(posedge clk) begin
		if (sys_rst) begin
			count    <= 2'd0;
			out_data <= 9'h000;
			spare    <= 9'h000;
		end else if (clk_en) begin
			if (push && !pop) begin
				count <= count + 2'd1;
				if (count == 2'd0)
					out_data <= in_data;
				else
					spare <= in_data;
			end else if (pop && !push) begin
				count    <= count - 2'd1;
				out_data <= spare;
			end else if (push && pop) begin
				if (count == 2'd1)
					out_data <= in_data;
				else begin
					out_data <= spare;
					spare    <= in_data;
				end
			end
		end
	end
endmodule // atx_buf2
`default_nettype wire

// ===== src/atx_framer.v
// Transport stream transmit framer with input select, null fill and test pattern
`timescale 1ns/1ns
`default_nettype none
`include "atx_defs.vh"
module atx_framer #(
	parameter [31:0] SETTLE_CYC = `ATX_SETTLE_CYC
) (
	// Clock and control
	input  wire        clk,
	input  wire        clk_en,
	input  wire        sys_rst,
	// Configuration
	input  wire        fmt_204,
	input  wire        in_sel,
	input  wire        test_on,
	input  wire        prbs_long,
	input  wire        loss_is_fault,
	input  wire        loop_io,
	input  wire        loop_dig,
	input  wire        bw_narrow,
	input  wire        pll_prog_err,
	input  wire [15:0] rate_err_ppm,
	input  wire [15:0] pcr_jitter_ns,
	// Transmit input 0
	input  wire        rx0_valid,
	input  wire [7:0]  rx0_data,
	// Transmit input 1
	input  wire        rx1_valid,
	input  wire [7:0]  rx1_data,
	// Check byte source for 188 mode
	input  wire [7:0]  rs_byte,
	// Framed byte stream towards modulator
	output wire        tx_valid,
	input  wire        tx_ready,
	output wire [7:0]  tx_data,
	output wire        tx_sop,
	// Loopback return towards terrestrial side
	output reg         lb_valid,
	output reg  [7:0]  lb_data,
	// Serial bit for digital loopback, msb first
	output reg         ser_bit,
	// Status
	output reg         loss_sync,
	output reg         loss_fault,
	output reg         loss_alarm,
	output reg         clk_locked,
	output reg         pll_err,
	output reg         data_viol,
	output reg         buf_fault,
	output reg         pcr_ok,
	output wire [15:0] loop_bw_mhz,
	output wire [15:0] line_rate_mbps
);
	reg  [7:0]  idx;
	reg  [7:0]  in_idx;
	reg         in_synced;
	reg  [3:0]  miss;
	reg  [22:0] lfsr;
	reg  [2:0]  bitpos;
	reg  [7:0]  shreg;
	reg  [31:0] settle_cnt;
	reg  [7:0]  next_byte;
	reg  [7:0]  prbs_byte;
	reg  [22:0] next_lfsr;
	reg         fb;
	integer     k;
	wire        src_valid;
	wire [7:0]  src_data;
	wire [7:0]  last_idx;
	wire        b_ready;
	wire        b_valid;
	wire [8:0]  b_data;
	wire        b_ovf;
	wire        emit;
	wire        in_viol;

	assign line_rate_mbps = `ATX_LINE_MBPS;
	assign loop_bw_mhz = bw_narrow ? `ATX_BW_NARROW_MHZ : `ATX_BW_WIDE_MHZ;
	assign src_valid = in_sel ? rx1_valid : rx0_valid;
	assign src_data  = in_sel ? rx1_data : rx0_data;
	// Input frames stay 188 long in 188 mode, 204 long in 204 mode
	assign last_idx = fmt_204 ? `ATX_LAST_204 : `ATX_LAST_188;
	assign in_viol = src_valid && (in_idx == 8'd0) && (src_data != `ATX_SYNC_BYTE);
	// A byte leaves every cycle the buffer can take one; the output frame never waits for input
	assign emit = b_ready & clk_en;

	// Track input framing; input bytes not consumed while in test or loss are dropped
	always @(posedge clk) begin
		if (sys_rst) begin
			in_idx    <= 8'd0;
			in_synced <= 1'b0;
			miss      <= 4'd0;
			data_viol <= 1'b0;
		end else if (clk_en) begin
			data_viol <= in_viol;
			if (src_valid) begin
				if (in_viol) begin
					in_idx    <= 8'd0;
					in_synced <= 1'b0;
				end else begin
					in_idx <= (in_idx == last_idx) ? 8'd0 : in_idx + 8'd1;
					if (in_idx == 8'd0)
						in_synced <= 1'b1;
				end
			end
			// Input is lost after several output frames with no input byte
			if (src_valid)
				miss <= 4'd0;
			else if (emit && idx == 8'd0 && miss != `ATX_LOSS_FRAMES)
				miss <= miss + 4'd1;
		end
	end

	// Output byte selection
	always @* begin
		prbs_byte = 8'h00;
		next_lfsr = lfsr;
		for (k = 0; k < 8; k = k + 1) begin
			if (prbs_long)
				fb = next_lfsr[`ATX_PRBS23_TAP_A] ^ next_lfsr[`ATX_PRBS23_TAP_B];
			else
				fb = next_lfsr[`ATX_PRBS11_TAP_A] ^ next_lfsr[`ATX_PRBS11_TAP_B];
			prbs_byte = {prbs_byte[6:0], fb};
			next_lfsr = {next_lfsr[21:0], fb};
		end
		if (idx == 8'd0)
			next_byte = `ATX_SYNC_BYTE;
		else if (!fmt_204 && idx > `ATX_LAST_188)
			next_byte = rs_byte;
		else if (test_on)
			next_byte = prbs_byte;
		else if (loss_sync || !in_synced || !src_valid) begin
			if (idx == `ATX_IDX_PID_HI)
				next_byte = `ATX_NULL_PID_HI;
			else if (idx == `ATX_IDX_PID_LO)
				next_byte = `ATX_NULL_PID_LO;
			else if (idx == `ATX_IDX_FLAGS)
				next_byte = `ATX_NULL_FLAGS;
			else
				next_byte = `ATX_NULL_FILL;
		end else
			next_byte = src_data;
	end

	// Output frame counter, pattern state and status
	always @(posedge clk) begin
		if (sys_rst) begin
			idx        <= 8'd0;
			lfsr       <= `ATX_PRBS_SEED;
			loss_sync  <= 1'b1;
			loss_fault <= 1'b0;
			loss_alarm <= 1'b0;
			clk_locked <= 1'b0;
			pll_err    <= 1'b0;
			buf_fault  <= 1'b0;
			settle_cnt <= 32'd0;
			pcr_ok     <= 1'b0;
		end else if (clk_en) begin
			if (emit) begin
				// Output frame is always 204 bytes on the satellite side
				idx <= (idx == `ATX_LAST_204) ? 8'd0 : idx + 8'd1;
				if (test_on && idx != 8'd0 && (fmt_204 || idx <= `ATX_LAST_188))
					lfsr <= next_lfsr;
			end
			loss_sync  <= (miss == `ATX_LOSS_FRAMES) || !in_synced;
			loss_fault <= loss_sync & loss_is_fault;
			loss_alarm <= loss_sync & ~loss_is_fault;
			clk_locked <= !pll_prog_err && (rate_err_ppm <= `ATX_PPM_WINDOW);
			pll_err    <= pll_prog_err;
			buf_fault  <= buf_fault | b_ovf;
			// Settling window, then the tighter bound must hold
			if (settle_cnt != SETTLE_CYC)
				settle_cnt <= settle_cnt + 32'd1;
			if (settle_cnt != SETTLE_CYC)
				pcr_ok <= (pcr_jitter_ns < `ATX_PCR_SETTLE_NS);
			else
				pcr_ok <= (pcr_jitter_ns < `ATX_PCR_FINAL_NS);
		end
	end

	atx_buf2 u_buf (
		.clk       (clk),
		.clk_en    (clk_en),
		.sys_rst   (sys_rst),
		.in_valid  (emit),
		.in_ready  (b_ready),
		.in_data   ({(idx == 8'd0), next_byte}),
		.out_valid (b_valid),
		.out_ready (tx_ready),
		.out_data  (b_data),
		.overflow  (b_ovf)
	);

	assign tx_valid = b_valid & ~loop_io;
	assign tx_data  = b_data[7:0];
	assign tx_sop   = b_data[8];

	// Loopbacks and msb-first serialiser
	always @(posedge clk) begin
		if (sys_rst) begin
			lb_valid <= 1'b0;
			lb_data  <= 8'h00;
			bitpos   <= 3'd0;
			shreg    <= 8'h00;
			ser_bit  <= 1'b0;
		end else if (clk_en) begin
			lb_valid <= loop_io ? src_valid : (loop_dig & b_valid & tx_ready);
			lb_data  <= loop_io ? src_data : b_data[7:0];
			if (loop_dig) begin
				ser_bit <= shreg[7];
				if (bitpos == 3'd0)
					shreg <= b_data[7:0];
				else
					shreg <= {shreg[6:0], 1'b0};
				bitpos <= bitpos + 3'd1;
			end
		end
	end
endmodule // atx_framer
`default_nettype wire

// ===== test/atx_chk.sv
// Assertion checker for the transport stream transmit framer
`timescale 1ns/1ns
`default_nettype none
module atx_chk (
	// Clock, reset and controls
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        bw_narrow,
	input wire logic        loop_io,
	input wire logic        pll_prog_err,
	// Outputs watched
	input wire logic        tx_valid,
	input wire logic        tx_ready,
	input wire logic [7:0]  tx_data,
	input wire logic        tx_sop,
	input wire logic        loss_fault,
	input wire logic        loss_alarm,
	input wire logic        pll_err,
	input wire logic        buf_fault,
	input wire logic [15:0] loop_bw_mhz,
	input wire logic [15:0] line_rate_mbps
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_stall; tx_valid && !tx_ready; endsequence
	sequence s_held; tx_valid && $stable(tx_data) && $stable(tx_sop); endsequence
	property p_sync; tx_valid && tx_sop |-> tx_data == 8'h47; endproperty
	property p_hold; s_stall |=> s_held; endproperty
	property p_bw; loop_bw_mhz == (bw_narrow ? 16'h01f4 : 16'h07d0); endproperty
	property p_rate; line_rate_mbps == 16'h010e; endproperty
	property p_loop; loop_io && $past(loop_io) |-> !tx_valid; endproperty
	property p_excl; !(loss_fault && loss_alarm); endproperty
	property p_pll; $rose(pll_prog_err) |-> ##[1:2] pll_err; endproperty
	property p_buf; !buf_fault; endproperty
	a_sync: assert property (p_sync) else $error("sop byte is not sync");
	a_hold: assert property (p_hold) else $error("stalled byte changed");
	a_bw: assert property (p_bw) else $error("loop bandwidth wrong");
	a_rate: assert property (p_rate) else $error("line rate wrong");
	a_loop: assert property (p_loop) else $error("tx_valid in loopback");
	a_excl: assert property (p_excl) else $error("fault and alarm both set");
	a_pll: assert property (p_pll) else $error("pll error not reported");
	a_buf: assert property (p_buf) else $error("buffer fault in normal use");
endmodule // atx_chk
bind atx_framer atx_chk atx_chk_i (.clk, .sys_rst, .bw_narrow, .loop_io, .pll_prog_err,
	.tx_valid, .tx_ready, .tx_data, .tx_sop, .loss_fault, .loss_alarm, .pll_err,
	.buf_fault, .loop_bw_mhz, .line_rate_mbps);
`default_nettype wire

// ===== test/atx_src.sv
// Terrestrial source model sending transport packets from a sync byte until on goes low, even mid-packet
`timescale 1ns/1ns
`default_nettype none
module atx_src (
	// Clock and control
	input  wire logic       clk,
	input  wire logic       on,
	input  wire logic       fmt_204,
	// Byte stream
	output logic            valid,
	output logic [7:0]      data
);
	logic [7:0] idx;
	initial begin
		valid = 1'b0;
		data = 8'h00;
		idx = 8'h00;
	end
	always @(negedge clk) begin
		if (!on) begin
			valid <= 1'b0;
			// Idle line toggles so no stale byte looks valid
			data <= ~data;
			idx <= 8'h00;
		end else begin
			valid <= 1'b1;
			data <= (idx == 8'h00) ? 8'h47 : idx;
			idx <= (idx == (fmt_204 ? 8'd203 : 8'd187)) ? 8'h00 : idx + 8'h01;
		end
	end
endmodule // atx_src
`default_nettype wire

// ===== test/atx_framer_tb.sv
// Self-checking bench for the transport stream transmit framer
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_total++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module atx_framer_tb;
	logic       clk = 1'b0, sys_rst = 1'b1, fmt_204 = 1'b0, in_sel = 1'b0, test_on = 1'b0;
	logic       prbs_long = 1'b0, loss_is_fault = 1'b0, loop_io = 1'b0, loop_dig = 1'b0;
	logic       bw_narrow = 1'b0, pll_prog_err = 1'b0, tx_ready = 1'b0, on0 = 1'b0, on1 = 1'b0;
	logic [7:0] rs_byte = 8'ha5;
	logic [15:0] rate_err = 16'h0000, jitter = 16'h0000;
	wire        rx0_valid, rx1_valid, tx_valid, tx_sop, loss_sync, loss_fault, loss_alarm, pll_err;
	wire        clk_locked, pcr_ok, lb_valid;
	wire [7:0]  rx0_data, rx1_data, tx_data;
	wire [15:0] loop_bw_mhz;
	int         err_total = 0, checks = 0, cyc = 0, n, k;
	logic [7:0] fb [0:255];
	atx_src atx_src_a (.clk(clk), .on(on0), .fmt_204(fmt_204), .valid(rx0_valid), .data(rx0_data));
	atx_src atx_src_b (.clk(clk), .on(on1), .fmt_204(fmt_204), .valid(rx1_valid), .data(rx1_data));
	atx_framer #(.SETTLE_CYC(32'd100)) atx_framer_i (.clk(clk), .clk_en(1'b1), .sys_rst(sys_rst),
		.fmt_204(fmt_204), .in_sel(in_sel), .test_on(test_on), .prbs_long(prbs_long),
		.loss_is_fault(loss_is_fault), .loop_io(loop_io), .loop_dig(loop_dig),
		.bw_narrow(bw_narrow), .pll_prog_err(pll_prog_err), .rate_err_ppm(rate_err),
		.pcr_jitter_ns(jitter), .rx0_valid(rx0_valid), .rx0_data(rx0_data),
		.rx1_valid(rx1_valid), .rx1_data(rx1_data), .rs_byte(rs_byte), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_data(tx_data), .tx_sop(tx_sop), .lb_valid(lb_valid), .lb_data(),
		.ser_bit(), .loss_sync(loss_sync), .loss_fault(loss_fault), .loss_alarm(loss_alarm),
		.clk_locked(clk_locked), .pll_err(pll_err), .data_viol(), .buf_fault(), .pcr_ok(pcr_ok),
		.loop_bw_mhz(loop_bw_mhz), .line_rate_mbps());
	always #50 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			err_total++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Collects one whole frame; stalling makes the buffer fill and refuse
	task automatic get_frame(input bit stall);
		bit got = 0;
		n = 0;
		for (int i = 0; i < 2000; i++) begin
			@(negedge clk);
			tx_ready = !stall || (i % 3 != 0);
			#1;
			if (tx_valid && tx_ready) begin
				if (tx_sop && got) break;
				if (tx_sop) got = 1;
				if (got && n < 256) begin
					fb[n] = tx_data;
					n++;
				end
			end
		end
	endtask
	task automatic t_null();
		get_frame(1);
		`CHK(n, 204)
		`CHK({fb[0], fb[1], fb[2], fb[3]}, 32'h471f_ff10)
		`CHK(fb[100], 8'hff)
		`CHK(loss_sync, 1'b1)
		`CHK(loss_alarm, 1'b1)
		loss_is_fault = 1'b1;
		repeat (3) @(negedge clk);
		`CHK({loss_fault, loss_alarm}, 2'b10)
		loss_is_fault = 1'b0;
	endtask
	task automatic t_prbs();
		test_on = 1'b1;
		for (k = 0; k < 2; k++) begin
			prbs_long = k[0];
			get_frame(1);
			`CHK(n, 204)
			`CHK(fb[1] == 8'h1f && fb[2] == 8'hff, 1'b0)
			`CHK(fb[190], rs_byte)
		end
		test_on = 1'b0;
	endtask
	task automatic t_pass();
		fmt_204 = 1'b1;
		in_sel = 1'b1;
		on1 = 1'b1;
		for (k = 0; k < 3000 && loss_sync !== 1'b0; k++) @(negedge clk);
		`CHK(loss_sync, 1'b0)
		get_frame(0);
		`CHK(n, 204)
		`CHK(fb[150] - fb[149], 8'h01)
		in_sel = 1'b0;
		for (k = 0; k < 3000 && loss_sync !== 1'b1; k++) @(negedge clk);
		`CHK(loss_sync, 1'b1)
		on1 = 1'b0;
	endtask
	task automatic t_ctl();
		for (k = 0; k < 2; k++) begin
			bw_narrow = k[0];
			#1;
			`CHK(loop_bw_mhz, k[0] ? 16'h01f4 : 16'h07d0)
		end
		pll_prog_err = 1'b1;
		repeat (3) @(negedge clk);
		`CHK(pll_err, 1'b1)
		{loop_io, loop_dig} = 2'b11;
		on0 = 1'b1;
		repeat (3) @(negedge clk);
		`CHK(tx_valid, 1'b0)
		`CHK(lb_valid, 1'b1)
		{loop_io, loop_dig, pll_prog_err} = 3'b000;
		on0 = 1'b0;
	endtask
	// Lock window edges, then a mid-run reset to restart the jitter settling window
	task automatic t_meas();
		rate_err = 16'h0064;
		repeat (2) @(negedge clk);
		`CHK(clk_locked, 1'b1)
		rate_err = 16'h0065;
		repeat (2) @(negedge clk);
		`CHK(clk_locked, 1'b0)
		sys_rst = 1'b1;
		jitter = 16'h0190;
		repeat (2) @(negedge clk);
		sys_rst = 1'b0;
		repeat (2) @(negedge clk);
		`CHK(pcr_ok, 1'b1)
		repeat (120) @(negedge clk);
		`CHK(pcr_ok, 1'b0)
		jitter = 16'h0063;
		repeat (2) @(negedge clk);
		`CHK(pcr_ok, 1'b1)
	endtask
	initial begin
		repeat (10) @(negedge clk);
		sys_rst = 1'b0;
		t_null();
		t_prbs();
		t_pass();
		t_ctl();
		t_meas();
		complete_run();
	end
endmodule // atx_framer_tb
`default_nettype wire
